// File: design/btc_cmp.sv
`timescale 1ns/1ps
module btc_cmp (
	btc_cmp_if.cmp cif
);
	assign cif.eq_a = (cif.addr == cif.cmp_a);
	assign cif.eq_b = (cif.addr == cif.cmp_b);
	// data compares against the low byte of comparator b
	assign cif.data_eq = (cif.data == cif.cmp_b[7:0]);
	assign cif.ge_a = (cif.addr >= cif.cmp_a);
	assign cif.le_b = (cif.addr <= cif.cmp_b);
	assign cif.dir_ok = ~cif.dir_chk | (cif.rw == cif.exp_dir);
endmodule : btc_cmp

// File: design/btc_fifo.sv
`timescale 1ns/1ps
module btc_fifo #(
	parameter int DW = 8,
	parameter int DEPTH = 8,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic push,
	input wire logic [DW-1:0] wdata,
	input wire logic pop,
	output logic [DW-1:0] rdata,
	output logic full,
	output logic empty,
	output logic [CW-1:0] count
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

	logic [DW-1:0] mem_ff [DEPTH];
	logic [PW-1:0] wp_ff;
	logic [PW-1:0] rp_ff;
	logic [CW-1:0] cnt_ff;
	wire do_push = push & ~full;
	wire do_pop = pop & ~empty;

	function automatic logic [PW-1:0] btc_inc(input logic [PW-1:0] p);
		btc_inc = (p == LAST_C) ? '0 : p + 1'b1;
	endfunction : btc_inc

	assign full = (cnt_ff == DEPTH_C);
	assign empty = (cnt_ff == '0);
	assign count = cnt_ff;
	assign rdata = mem_ff[rp_ff];

	always_ff @(posedge clock) begin
		if (do_push)
			mem_ff[wp_ff] <= wdata;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else if (clear) begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (do_push)
				wp_ff <= btc_inc(wp_ff);
			if (do_pop)
				rp_ff <= btc_inc(rp_ff);
			cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule : btc_fifo

// File: design/btc_top.sv
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "btc_cfg.svh"
// Notes on behaviour
// - mode a-only triggers on address equals a
// - either comparator address match triggers
// - b match triggers only after earlier a
// - full mode: address and data match, direction too when checked
// - full mode: address matches, data differs
// - tag in full mode uses address a only
// - event b mode captures data each b match
// - armed event mode waits for a first
// - store modes end run when fifo full
// - inside range, both bounds inclusive
// - outside range, strictly below a or above b
module btc_top #(
	parameter int AW = 16,
	parameter int DEPTH = `BTC_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic bus_valid,
	input wire logic [AW-1:0] bus_addr,
	input wire logic [7:0] bus_data,
	input wire logic bus_rw,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic trig,
	output logic brk_req,
	output logic tag_req,
	output logic run_active,
	output logic irq
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [1:0] rst_sync_ff;
	wire rst_n_s = rst_sync_ff[1];

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rst_sync_ff <= 2'h0;
		else
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
	end

	logic [AW-1:0] cmpa_ff, cmpb_ff;
	btc_pkg::btc_mode_t mode_ff;
	logic dirchk_ff, expdir_ff, breakpoint_enable_ff, tag_ff;
	logic [`BTC_ST_W-1:0] stat_ff, mask_ff;
	btc_pkg::btc_state_t state_ff, nxt_state;
	logic a_seen_ff;
	logic trig_ff, brk_ff, tagq_ff, run_ff, irq_ff;
	logic [15:0] rdata_ff;

	// register decode
	wire wr_cmpa = reg_wr & (reg_addr == `BTC_OFF_CMPA);
	wire wr_cmpb = reg_wr & (reg_addr == `BTC_OFF_CMPB);
	wire wr_ctrl = reg_wr & (reg_addr == `BTC_OFF_CTRL);
	wire wr_stat = reg_wr & (reg_addr == `BTC_OFF_STAT);
	wire wr_mask = reg_wr & (reg_addr == `BTC_OFF_MASK);
	wire rd_fifo = reg_rd & (reg_addr == `BTC_OFF_FIFO);
	wire go = wr_ctrl & reg_wdata[`BTC_CTRL_GO];

	function automatic logic btc_is_store(input btc_pkg::btc_mode_t m);
		btc_is_store = (m == btc_pkg::BTC_M_EV_B) ||
			(m == btc_pkg::BTC_M_A_THEN_EV_B);
	endfunction : btc_is_store

	function automatic logic btc_is_full(input btc_pkg::btc_mode_t m);
		btc_is_full = (m == btc_pkg::BTC_M_FULL_EQ) ||
			(m == btc_pkg::BTC_M_FULL_NE);
	endfunction : btc_is_full

	btc_cmp_if #(.AW(AW)) cif ();
	assign cif.addr = bus_addr;
	assign cif.cmp_a = cmpa_ff;
	assign cif.cmp_b = cmpb_ff;
	assign cif.data = bus_data;
	assign cif.rw = bus_rw;
	assign cif.dir_chk = dirchk_ff;
	assign cif.exp_dir = expdir_ff;

	btc_cmp u_cmp (
		.cif(cif.cmp)
	);

	// one evaluation per bus cycle while the run is live
	wire sample = bus_valid & (state_ff == btc_pkg::BTC_ST_RUN);
	wire full_addr = cif.eq_a & cif.dir_ok;
	logic [9:0] hit_vec;
	assign hit_vec[0] = cif.eq_a;
	assign hit_vec[1] = cif.eq_a | cif.eq_b;
	assign hit_vec[2] = a_seen_ff & cif.eq_b;
	assign hit_vec[3] = full_addr & cif.data_eq;
	assign hit_vec[4] = full_addr & ~cif.data_eq;
	assign hit_vec[5] = cif.eq_b;
	assign hit_vec[6] = a_seen_ff & cif.eq_b;
	assign hit_vec[7] = cif.ge_a & cif.le_b;
	assign hit_vec[8] = ~cif.ge_a | ~cif.le_b;
	assign hit_vec[9] = 1'b0;
	wire mode_ok = (mode_ff < `BTC_MODE_COUNT);
	wire mode_hit = mode_ok & hit_vec[mode_ff];
	wire hit = sample & mode_hit;
	wire store = btc_is_store(mode_ff);
	wire seq_mode = (mode_ff == btc_pkg::BTC_M_A_THEN_B) ||
		(mode_ff == btc_pkg::BTC_M_A_THEN_EV_B);
	// a tag request in a full mode ignores the data comparison
	wire tag_hit = btc_is_full(mode_ff) ? (sample & cif.eq_a) : hit;

	logic fifo_full;
	logic fifo_empty;
	logic [7:0] fifo_rdata;
	logic [CW-1:0] fifo_count;
	wire push = hit & store;

	btc_fifo #(.DW(8), .DEPTH(DEPTH), .CW(CW)) u_fifo (
		.clock(clock),
		.rst_n(rst_n_s),
		.clear(go),
		.push(push),
		.wdata(bus_data),
		.pop(rd_fifo),
		.rdata(fifo_rdata),
		.full(fifo_full),
		.empty(fifo_empty),
		.count(fifo_count)
	);

	// run sequencing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			btc_pkg::BTC_ST_IDLE: begin
				if (go)
					nxt_state = btc_pkg::BTC_ST_RUN;
			end
			btc_pkg::BTC_ST_RUN: begin
				if (go)
					nxt_state = btc_pkg::BTC_ST_RUN;
				else if (store && fifo_full)
					nxt_state = btc_pkg::BTC_ST_DONE;
				else if (!store && hit)
					nxt_state = btc_pkg::BTC_ST_DONE;
			end
			btc_pkg::BTC_ST_DONE: begin
				if (go)
					nxt_state = btc_pkg::BTC_ST_RUN;
			end
			default: nxt_state = btc_pkg::BTC_ST_IDLE;
		endcase
	end

	wire run_end = (state_ff == btc_pkg::BTC_ST_RUN) &
		(nxt_state == btc_pkg::BTC_ST_DONE);
	wire [`BTC_ST_W-1:0] ev_vec = {run_end, hit};
	wire [`BTC_ST_W-1:0] clr_vec = wr_stat ? reg_wdata[`BTC_ST_W-1:0] : '0;
	// set wins over a write-one clear in the same cycle
	wire [`BTC_ST_W-1:0] nxt_stat = (stat_ff & ~clr_vec) | ev_vec;
	wire nxt_aseen = go ? 1'b0 : (a_seen_ff | (sample & seq_mode & cif.eq_a));

	always_ff @(posedge clock or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state_ff <= btc_pkg::BTC_ST_IDLE;
			a_seen_ff <= 1'b0;
			stat_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			a_seen_ff <= nxt_aseen;
			stat_ff <= nxt_stat;
		end
	end

	always_ff @(posedge clock or negedge rst_n_s) begin
		if (!rst_n_s) begin
			cmpa_ff <= AW'(`BTC_RST_CMP);
			cmpb_ff <= AW'(`BTC_RST_CMP);
			mode_ff <= btc_pkg::btc_mode_t'(`BTC_RST_MODE);
			{tag_ff, breakpoint_enable_ff, expdir_ff, dirchk_ff} <= 4'h0;
			mask_ff <= `BTC_RST_MASK;
		end else begin
			if (wr_cmpa)
				cmpa_ff <= reg_wdata[AW-1:0];
			if (wr_cmpb)
				cmpb_ff <= reg_wdata[AW-1:0];
			if (wr_ctrl) begin
				mode_ff <= btc_pkg::btc_mode_t'(
					reg_wdata[`BTC_CTRL_MODE_MSB:`BTC_CTRL_MODE_LSB]);
				dirchk_ff <= reg_wdata[`BTC_CTRL_DIRCHK];
				expdir_ff <= reg_wdata[`BTC_CTRL_EXPDIR];
				breakpoint_enable_ff <= reg_wdata[`BTC_CTRL_BREAKPOINT_ENABLE];
				tag_ff <= reg_wdata[`BTC_CTRL_TAG];
			end
			if (wr_mask)
				mask_ff <= reg_wdata[`BTC_ST_W-1:0];
		end
	end

	// read mux
	logic [15:0] rd_mux;
	wire [15:0] ctrl_rd = {8'h00, tag_ff, breakpoint_enable_ff, expdir_ff, dirchk_ff,
		mode_ff};
	wire [15:0] info_rd = {(16 - `BTC_INFO_CNT_LSB)'(fifo_count),
		5'h00, a_seen_ff, (state_ff == btc_pkg::BTC_ST_DONE),
		(state_ff == btc_pkg::BTC_ST_RUN)};
	always_comb begin
		case (reg_addr)
			`BTC_OFF_CMPA: rd_mux = 16'(cmpa_ff);
			`BTC_OFF_CMPB: rd_mux = 16'(cmpb_ff);
			`BTC_OFF_CTRL: rd_mux = ctrl_rd;
			`BTC_OFF_STAT: rd_mux = {14'h0000, stat_ff};
			`BTC_OFF_MASK: rd_mux = {14'h0000, mask_ff};
			`BTC_OFF_FIFO: rd_mux = fifo_empty ? 16'h0000 : {8'h00, fifo_rdata};
			`BTC_OFF_INFO: rd_mux = info_rd;
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n_s) begin
		if (!rst_n_s) begin
			rdata_ff <= 16'h0000;
			trig_ff <= 1'b0;
			brk_ff <= 1'b0;
			tagq_ff <= 1'b0;
			run_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			rdata_ff <= reg_rd ? rd_mux : 16'h0000;
			trig_ff <= hit;
			brk_ff <= breakpoint_enable_ff & ~tag_ff & hit;
			tagq_ff <= breakpoint_enable_ff & tag_ff & tag_hit;
			run_ff <= (nxt_state == btc_pkg::BTC_ST_RUN);
			irq_ff <= |(nxt_stat & mask_ff);
		end
	end

	assign reg_rdata = rdata_ff;
	assign trig = trig_ff;
	assign brk_req = brk_ff;
	assign tag_req = tagq_ff;
	assign run_active = run_ff;
	assign irq = irq_ff;

	wire is_run = (state_ff == btc_pkg::BTC_ST_RUN);
	wire bv = bus_valid;
	wire [AW-1:0] ba = bus_addr;
	wire [AW-1:0] ca = cmpa_ff;
	wire [AW-1:0] cb = cmpb_ff;

	property p_a_only;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && bv && mode_ff == btc_pkg::BTC_M_A_ONLY && ba == ca)
			|=> trig;
	endproperty
	a_a_only: assert property (p_a_only) else $error("a-only miss");
	property p_a_or_b;
		@(posedge clock) disable iff (!rst_n_s)
		(mode_ff == btc_pkg::BTC_M_A_OR_B && $past(mode_ff) == mode_ff &&
			is_run && bv) |=> (trig == ($past(ba) == ca || $past(ba) == cb));
	endproperty
	a_a_or_b: assert property (p_a_or_b) else $error("a-or-b wrong");
	property p_seq;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && bv && mode_ff == btc_pkg::BTC_M_A_THEN_B && !a_seen_ff)
			|=> !trig;
	endproperty
	a_seq: assert property (p_seq) else $error("b before a");
	property p_full_eq;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && bv && mode_ff == btc_pkg::BTC_M_FULL_EQ &&
			bus_data != cb[7:0]) |=> !trig;
	endproperty
	a_full_eq: assert property (p_full_eq) else $error("full eq data");
	property p_full_dir;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && bv && btc_is_full(mode_ff) && dirchk_ff &&
			bus_rw != expdir_ff) |=> !trig;
	endproperty
	a_full_dir: assert property (p_full_dir) else $error("full dir");
	property p_tag;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && bv && btc_is_full(mode_ff) && breakpoint_enable_ff && tag_ff &&
			ba == ca) |=> tag_req && !brk_req;
	endproperty
	a_tag: assert property (p_tag) else $error("tag not on a");
	property p_store;
		@(posedge clock) disable iff (!rst_n_s)
		(push && !fifo_full && !go && !rd_fifo)
			|=> fifo_count == $past(fifo_count) + 1'b1;
	endproperty
	a_store: assert property (p_store) else $error("no capture");
	property p_armed;
		@(posedge clock) disable iff (!rst_n_s)
		(mode_ff == btc_pkg::BTC_M_A_THEN_EV_B && !a_seen_ff) |-> !push;
	endproperty
	a_armed: assert property (p_armed) else $error("capture unarmed");
	property p_end;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && store && fifo_full && !go) |=>
			state_ff == btc_pkg::BTC_ST_DONE ##1 !run_active;
	endproperty
	a_end: assert property (p_end) else $error("run not ended");
	property p_range;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && bv && mode_ff == btc_pkg::BTC_M_INSIDE)
			|=> (trig == ($past(ba) >= ca && $past(ba) <= cb));
	endproperty
	a_range: assert property (p_range) else $error("inside wrong");
	property p_out;
		@(posedge clock) disable iff (!rst_n_s)
		(is_run && bv && mode_ff == btc_pkg::BTC_M_OUTSIDE && ba >= ca &&
			ba <= cb) |=> !trig;
	endproperty
	a_out: assert property (p_out) else $error("outside wrong");
	property p_once;
		@(posedge clock) disable iff (!rst_n_s)
		(!bv || !is_run || !mode_ok) |=> !trig;
	endproperty
	a_once: assert property (p_once) else $error("stray trigger");

	c_seq: cover property (@(posedge clock) disable iff (!rst_n_s)
		mode_ff == btc_pkg::BTC_M_A_THEN_B && a_seen_ff && trig);
	c_full: cover property (@(posedge clock) disable iff (!rst_n_s)
		is_run && store && fifo_full ##1 state_ff == btc_pkg::BTC_ST_DONE);
	c_irq: cover property (@(posedge clock) disable iff (!rst_n_s)
		$rose(irq));
endmodule : btc_top

// File: shared/btc_cfg.svh
`ifndef BTC_CFG_SVH
`define BTC_CFG_SVH

// register word offsets on the plain register port
`define BTC_OFF_CMPA 4'h0
`define BTC_OFF_CMPB 4'h1
`define BTC_OFF_CTRL 4'h2
`define BTC_OFF_STAT 4'h3
`define BTC_OFF_MASK 4'h4
`define BTC_OFF_FIFO 4'h5
`define BTC_OFF_INFO 4'h6

// control register fields
`define BTC_CTRL_MODE_LSB 0
`define BTC_CTRL_MODE_MSB 3
`define BTC_CTRL_DIRCHK 4
`define BTC_CTRL_EXPDIR 5
`define BTC_CTRL_BREAKPOINT_ENABLE 6
`define BTC_CTRL_TAG 7
`define BTC_CTRL_GO 8

// status and mask fields
`define BTC_ST_TRIG 0
`define BTC_ST_END 1
`define BTC_ST_W 2

// info register fields
`define BTC_INFO_RUN 0
`define BTC_INFO_DONE 1
`define BTC_INFO_ASEEN 2
`define BTC_INFO_CNT_LSB 8

// reset values and counts
`define BTC_RST_CMP 16'h0000
`define BTC_RST_MODE 4'h0
`define BTC_RST_MASK 2'h0
`define BTC_MODE_COUNT 4'ha
`define BTC_FIFO_DEPTH 8

`endif

// File: shared/btc_cmp_if.sv
`timescale 1ns/1ps
interface btc_cmp_if #(
	parameter int AW = 16
);
	logic [AW-1:0] addr;
	logic [AW-1:0] cmp_a;
	logic [AW-1:0] cmp_b;
	logic [7:0] data;
	logic rw;
	logic dir_chk;
	logic exp_dir;
	logic eq_a;
	logic eq_b;
	logic data_eq;
	logic ge_a;
	logic le_b;
	logic dir_ok;

	modport cmp (
		input addr, cmp_a, cmp_b, data, rw, dir_chk, exp_dir,
		output eq_a, eq_b, data_eq, ge_a, le_b, dir_ok
	);
	modport user (
		output addr, cmp_a, cmp_b, data, rw, dir_chk, exp_dir,
		input eq_a, eq_b, data_eq, ge_a, le_b, dir_ok
	);
endinterface : btc_cmp_if

// File: shared/btc_pkg.sv
package btc_pkg;

	typedef enum logic [3:0] {
		BTC_M_A_ONLY = 4'h0,
		BTC_M_A_OR_B = 4'h1,
		BTC_M_A_THEN_B = 4'h2,
		BTC_M_FULL_EQ = 4'h3,
		BTC_M_FULL_NE = 4'h4,
		BTC_M_EV_B = 4'h5,
		BTC_M_A_THEN_EV_B = 4'h6,
		BTC_M_INSIDE = 4'h7,
		BTC_M_OUTSIDE = 4'h8,
		BTC_M_RSVD9 = 4'h9
	} btc_mode_t;

	typedef enum logic [2:0] {
		BTC_ST_IDLE = 3'b001,
		BTC_ST_RUN = 3'b010,
		BTC_ST_DONE = 3'b100
	} btc_state_t;

endpackage : btc_pkg

// File: tb/btc_bus_model.sv
`timescale 1ns/1ps
module btc_bus_model (
	input wire logic clock,
	input wire logic brk_req,
	input wire logic tag_req,
	output logic bus_valid,
	output logic [15:0] bus_addr,
	output logic [7:0] bus_data,
	output logic bus_rw
);
	int brk_seen = 0;
	int tag_seen = 0;
	initial begin
		bus_valid = 1'b0;
		bus_addr = 16'h0000;
		bus_data = 8'h00;
		bus_rw = 1'b0;
	end
	// one bus cycle; idle lines then show the inverse, not the old value
	task automatic cycle(input logic [15:0] a, input logic [7:0] d,
		input logic rw);
		@(posedge clock);
		bus_valid <= 1'b1;
		bus_addr <= a;
		bus_data <= d;
		bus_rw <= rw;
		@(posedge clock);
		bus_valid <= 1'b0;
		bus_addr <= ~a;
		bus_data <= ~d;
		bus_rw <= ~rw;
	endtask : cycle
	always @(posedge clock) begin
		if (brk_req === 1'b1) brk_seen <= brk_seen + 1;
		if (tag_req === 1'b1) tag_seen <= tag_seen + 1;
	end
endmodule : btc_bus_model

// File: tb/bus_trigger_comparator_tb.sv
`timescale 1ns/1ps
module bus_trigger_comparator_tb;
	localparam int DEPTH = 2;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic bus_valid, bus_rw, trig, brk_req, tag_req, run_active, irq;
	logic [15:0] bus_addr, reg_rdata;
	logic [7:0] bus_data;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	int seed = 32'hb3ad;
	int nbrk = 0;
	int ntag = 0;

	always #10 clock = ~clock;

	btc_top #(.AW(16), .DEPTH(DEPTH)) u_dut (.clock(clock), .rst_n(rst_n),
		.bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
		.bus_rw(bus_rw), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.trig(trig), .brk_req(brk_req), .tag_req(tag_req),
		.run_active(run_active), .irq(irq));
	btc_bus_model u_bus (.clock(clock), .brk_req(brk_req),
		.tag_req(tag_req), .bus_valid(bus_valid), .bus_addr(bus_addr),
		.bus_data(bus_data), .bus_rw(bus_rw));

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	function automatic logic hit(input logic [3:0] m,
		input logic [15:0] a, b, x, input logic [7:0] d,
		input logic dirok, seen);
		logic ea, eb;
		ea = (x == a);
		eb = (x == b);
		case (m)
			4'h0: hit = ea;
			4'h1: hit = ea | eb;
			4'h2, 4'h6: hit = eb & seen;
			4'h3: hit = ea & (d == b[7:0]) & dirok;
			4'h4: hit = ea & (d != b[7:0]) & dirok;
			4'h5: hit = eb;
			4'h7: hit = (x >= a) && (x <= b);
			4'h8: hit = (x < a) || (x > b);
			default: hit = 1'b0;
		endcase
	endfunction : hit

	task automatic run(input logic [3:0] m);
		logic [15:0] a, b, x, v, msk;
		logic [7:0] d;
		logic dc, ed, be, tg, rw, h, seen, live, any, done, full;
		logic [7:0] q[$];
		seen = 0;
		live = 1;
		any = 0;
		done = 0;
		full = (m == 4'h3) || (m == 4'h4);
		a = 16'($random(seed));
		b = (m > 4'h6) ? a + 16'h0004 : 16'($random(seed));
		{dc, ed, be, tg} = 4'($random(seed));
		msk = 16'($random(seed)) & 16'h0003;
		wr(4'h0, a);
		wr(4'h1, b);
		wr(4'h4, msk);
		wr(4'h2, {7'h00, 1'b1, tg, be, ed, dc, m});
		rd(4'h2, v);
		check("ctrl", {8'h00, tg, be, ed, dc, m}, v);
		for (int i = 0; i < 8; i++) begin
			case ($random(seed) & 3)
				0: x = a;
				1: x = b;
				2: x = a - 16'h0001;
				default: x = b + 16'h0001;
			endcase
			d = ($random(seed) & 1) ? b[7:0] : 8'($random(seed));
			rw = 1'($random(seed));
			u_bus.cycle(x, d, rw);
			#1;
			h = live & hit(m, a, b, x, d, !dc | (rw == ed), seen);
			check("trig", {15'h0, h}, {15'h0, trig});
			check("brk", {15'h0, h & be & !tg}, {15'h0, brk_req});
			v[0] = live & be & tg & (full ? (x == a) : h);
			check("tag", {15'h0, v[0]}, {15'h0, tag_req});
			nbrk += int'(h & be & !tg);
			ntag += int'(v[0]);
			if (live && (m == 4'h2 || m == 4'h6)) seen |= (x == a);
			if (h) begin
				any = 1;
				if (m == 4'h5 || m == 4'h6) q.push_back(d);
				if ((m != 4'h5 && m != 4'h6) || q.size() == DEPTH) begin
					live = 0;
					done = 1;
				end
			end
		end
		repeat (2) @(posedge clock);
		#1 check("run", {15'h0, live}, {15'h0, run_active});
		rd(4'h6, v);
		check("info", {8'(q.size()), 5'h00, seen, done, live}, v);
		rd(4'h3, v);
		check("status", {14'h0, done, any}, v);
		check("irq", {15'h0, |({done, any} & msk[1:0])}, {15'h0, irq});
		foreach (q[i]) begin
			rd(4'h5, v);
			check("fifo", {8'h00, q[i]}, v);
		end
		rd(4'h5, v);
		check("fifo empty", 16'h0000, v);
		wr(4'h3, 16'h0003);
		rd(4'h3, v);
		check("w1c", 16'h0000, v);
		check("irq clear", 16'h0000, {15'h0, irq});
	endtask : run

	initial begin
		logic [15:0] v;
		repeat (5) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		for (int i = 0; i < 16; i++) begin
			rd(i[3:0], v);
			check("reset value", 16'h0000, v);
		end
		wr(4'h9, 16'hffff);
		rd(4'h9, v);
		check("unmapped", 16'h0000, v);
		for (int r = 0; r < 3; r++) begin
			// mode index 10 stands for an undefined mode code, which never triggers
			for (int m = 0; m < 11; m++) begin
				run((m == 10) ? 4'hf : m[3:0]);
				$display("test mode %0d pass %0d done", m, r);
			end
		end
		@(posedge clock);
		#1 check("brk count", 16'(nbrk), 16'(u_bus.brk_seen));
		check("tag count", 16'(ntag), 16'(u_bus.tag_seen));
		print_verdict();
	end

	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			print_verdict();
		end
	end
endmodule : bus_trigger_comparator_tb
